/* card_port0_pin_selector.sv */
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
module card_port0_pin_selector (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pinmux_pkg::addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // card interface side
  input wire pinmux_pkg::card_side_t card,
  output logic card_cmd_in,
  output logic [3:0] card_dat_in,
  // audio port side
  input wire pinmux_pkg::audio_side_t audio,
  output logic audio_bclk_in,
  output logic audio_fs_in,
  output logic audio_rx_in,
  // gpio side
  input wire logic [pinmux_pkg::pin_count-1:0] gpio_out,
  input wire logic [pinmux_pkg::pin_count-1:0] gpio_oe_n,
  output logic [pinmux_pkg::pin_count-1:0] gpio_lines_low6_in,
  // shared pins
  input wire logic [pinmux_pkg::pin_count-1:0] pin_in,
  output logic [pinmux_pkg::pin_count-1:0] pin_out,
  output logic [pinmux_pkg::pin_count-1:0] pin_oe_n,
  output logic [pinmux_pkg::pin_count-1:0] pin_pd_off
);
  pinmux_pkg::port_mode_t mode;
  logic [pinmux_pkg::pin_count-1:0] pd_off;
  pinmux_pkg::pin_drive_t drive;
  pinmux_pkg::pin_drive_t drive_reg, drive_next;
  logic [pinmux_pkg::pin_count-1:0] pd_reg, pd_next;
  logic [pinmux_pkg::pin_count-1:0] gin_reg, gin_next;
  logic cmd_in_reg, cmd_in_next;
  logic [3:0] dat_in_reg, dat_in_next;
  logic bclk_in_reg, bclk_in_next;
  logic fs_in_reg, fs_in_next;
  logic rx_in_reg, rx_in_next;

  pinmux_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mode(mode),
    .pd_off(pd_off)
  );

  pinmux_route u_route (
    .mode(mode),
    .card(card),
    .audio(audio),
    .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n),
    .drive(drive)
  );

  // input side: deselected functions see idle zeros, not foreign pin traffic
  always_comb begin
    drive_next = drive;
    pd_next = pd_off;
    gin_next = '0;
    cmd_in_next = 1'b0;
    dat_in_next = 4'h0;
    bclk_in_next = 1'b0;
    fs_in_next = 1'b0;
    rx_in_next = 1'b0;
    unique case (mode)
      pinmux_pkg::mode_card: begin
        cmd_in_next = pin_in[pinmux_pkg::pin_cmd];
        dat_in_next = pin_in[pinmux_pkg::pin_d3:pinmux_pkg::pin_d0];
      end
      pinmux_pkg::mode_audio: begin
        bclk_in_next = pin_in[pinmux_pkg::pin_clk];
        fs_in_next = pin_in[pinmux_pkg::pin_cmd];
        rx_in_next = pin_in[pinmux_pkg::pin_d1];
        gin_next[pinmux_pkg::pin_d3:pinmux_pkg::pin_d2] = pin_in[pinmux_pkg::pin_d3:pinmux_pkg::pin_d2];
      end
      pinmux_pkg::mode_gpio: begin
        gin_next = pin_in;
      end
      pinmux_pkg::mode_rsvd: begin
        gin_next = '0;
      end
    endcase
  end

  // registered outputs cost one cycle of latency on every routed signal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_reg <= '{dout: '0, oe_n: '1};
      pd_reg <= pinmux_pkg::pd_off_reset;
      gin_reg <= '0;
      cmd_in_reg <= 1'b0;
      dat_in_reg <= 4'h0;
      bclk_in_reg <= 1'b0;
      fs_in_reg <= 1'b0;
      rx_in_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
      pd_reg <= pd_next;
      gin_reg <= gin_next;
      cmd_in_reg <= cmd_in_next;
      dat_in_reg <= dat_in_next;
      bclk_in_reg <= bclk_in_next;
      fs_in_reg <= fs_in_next;
      rx_in_reg <= rx_in_next;
    end
  end

  assign pin_out = drive_reg.dout;
  assign pin_oe_n = drive_reg.oe_n;
  assign pin_pd_off = pd_reg;
  assign gpio_lines_low6_in = gin_reg;
  assign card_cmd_in = cmd_in_reg;
  assign card_dat_in = dat_in_reg;
  assign audio_bclk_in = bclk_in_reg;
  assign audio_fs_in = fs_in_reg;
  assign audio_rx_in = rx_in_reg;

endmodule : card_port0_pin_selector

/* card_port0_pin_selector_chk.sv */
`timescale 1ns/1ps
module card_port0_pin_selector_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // functions and pins
  input wire pinmux_pkg::card_side_t card,
  input wire pinmux_pkg::audio_side_t audio,
  input wire logic [5:0] gpio_out,
  input wire logic [5:0] gpio_oe_n,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  input wire logic [5:0] pin_pd_off
);
  logic [7:0] cfg_reg, cfg_next, prev_reg;
  logic up_reg, wr, st;
  // shadow of what software wrote; routing is judged only once it has settled
  assign wr = psel && penable && pwrite;
  always_comb begin
    cfg_next = cfg_reg;
    if (wr && paddr == 12'h000) cfg_next[1:0] = pwdata[1:0];
    if (wr && paddr == 12'h004) cfg_next[7:2] = pwdata[5:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= 8'h00;
      prev_reg <= 8'h00;
      up_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      prev_reg <= cfg_reg;
      up_reg <= 1'b1;
    end
  end
  assign st = up_reg && cfg_reg == prev_reg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_card_clk: assert property (st && cfg_reg[1:0] == 2'h0 |-> !pin_oe_n[0] && pin_out[0] == $past(card.clk))
    else $error("card clock not on pin 0");
  chk_card_enables: assert property (st && cfg_reg[1:0] == 2'h0 |->
    pin_oe_n[5:1] == {$past(card.dat_oe_n), $past(card.cmd_oe_n)}) else $error("card enables wrong");
  chk_audio_route: assert property (st && cfg_reg[1:0] == 2'h1 |-> pin_out[2] == $past(audio.tx_data) &&
    pin_oe_n[3:0] == {2'h2, $past(audio.fs_oe_n), $past(audio.bclk_oe_n)}) else $error("audio pins wrong");
  chk_audio_gpio: assert property (st && cfg_reg[1:0] == 2'h1 |-> pin_oe_n[5:4] == $past(gpio_oe_n[5:4]))
    else $error("pins 4-5 not gpio");
  chk_gpio_route: assert property (st && cfg_reg[1:0] == 2'h2 |-> pin_oe_n == $past(gpio_oe_n) &&
    (pin_out | pin_oe_n) == ($past(gpio_out) | pin_oe_n)) else $error("gpio routing wrong");
  chk_rsvd_release: assert property (st && cfg_reg[1:0] == 2'h3 |-> pin_oe_n == 6'h3f)
    else $error("pins driven in code 11");
  chk_pd_follow: assert property (st |-> pin_pd_off == cfg_reg[7:2])
    else $error("pulldown bits wrong");
endmodule : card_port0_pin_selector_chk

bind card_port0_pin_selector card_port0_pin_selector_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .card, .audio, .gpio_out, .gpio_oe_n, .pin_out, .pin_oe_n, .pin_pd_off);

/* card_port0_pin_selector_tb_top.sv */
`timescale 1ns/1ps
module card_port0_pin_selector_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  pinmux_pkg::card_side_t card = 11'h000;
  pinmux_pkg::audio_side_t audio = 5'h00;
  logic [5:0] gpio_out = 6'h00;
  logic [5:0] gpio_oe_n = 6'h3f;
  logic [5:0] ext_val = 6'h00;
  logic [5:0] ext_en = 6'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, card_cmd_in, audio_bclk_in, audio_fs_in, audio_rx_in;
  logic [3:0] card_dat_in;
  logic [5:0] pin_in, pin_out, pin_oe_n, pin_pd_off, gpio_lines_low6_in;
  int errors = 0;
  int total_checks = 0;
  always #5 pclk = ~pclk;
  card_port0_pin_selector dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .card, .card_cmd_in, .card_dat_in, .audio, .audio_bclk_in, .audio_fs_in, .audio_rx_in,
    .gpio_out, .gpio_oe_n, .gpio_lines_low6_in, .pin_in, .pin_out, .pin_oe_n, .pin_pd_off);
  pad_load_model pads (.pclk, .pin_out, .pin_oe_n, .pin_pd_off, .ext_val, .ext_en, .pin_in);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic t_card();
    apb(1'b0, 12'h000, 32'h0);
    check("mode reset", rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    check("pd reset", rd, 32'h0);
    check("slverr", er, 1'b0);
    check("pready", pready, 1'b1);
    card <= 11'h553;
    ext_en <= 6'h0e;
    ext_val <= 6'h0a;
    repeat (4) @(posedge pclk);
    check("card oe", pin_oe_n, 6'h0e);
    check("card out", pin_out | pin_oe_n, 6'h1f);
    check("cmd in", card_cmd_in, 1'b1);
    check("dat in", card_dat_in, 4'h6);
    check("gpio in", gpio_lines_low6_in, 6'h00);
    $display("card test done");
  endtask : t_card
  task automatic t_audio();
    apb(1'b1, 12'h000, 32'h1);
    audio <= 5'h13;
    gpio_out <= 6'h10;
    gpio_oe_n <= 6'h0f;
    ext_en <= 6'h0a;
    ext_val <= 6'h0a;
    repeat (4) @(posedge pclk);
    check("audio oe", pin_oe_n, 6'h0a);
    check("audio out", pin_out | pin_oe_n, 6'h1f);
    check("fs rx bclk", {audio_fs_in, audio_rx_in, audio_bclk_in}, 3'h7);
    check("gpio in", gpio_lines_low6_in, 6'h10);
    check("dat in", card_dat_in, 4'h0);
    $display("audio test done");
  endtask : t_audio
  task automatic t_gpio();
    apb(1'b1, 12'h000, 32'h2);
    gpio_out <= 6'h2d;
    gpio_oe_n <= 6'h0c;
    ext_en <= 6'h0c;
    ext_val <= 6'h04;
    repeat (4) @(posedge pclk);
    check("gpio oe", pin_oe_n, 6'h0c);
    check("gpio out", pin_out | pin_oe_n, 6'h2d);
    check("gpio in", gpio_lines_low6_in, 6'h25);
    check("rx in", audio_rx_in, 1'b0);
    $display("gpio test done");
  endtask : t_gpio
  task automatic t_pd();
    apb(1'b1, 12'h004, 32'hffffffe5);
    apb(1'b0, 12'h004, 32'h0);
    check("pd read", rd, 32'h25);
    check("pd pins", pin_pd_off, 6'h25);
    apb(1'b1, 12'h000, 32'h0);
    repeat (2) @(posedge pclk);
    check("pd kept", pin_pd_off, 6'h25);
    $display("pulldown test done");
  endtask : t_pd
  task automatic t_rsvd();
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b0, 12'h000, 32'h0);
    check("mode read", rd, 32'h3);
    repeat (2) @(posedge pclk);
    check("rsvd oe", pin_oe_n, 6'h3f);
    check("rsvd in", {gpio_lines_low6_in, card_cmd_in}, 7'h00);
    apb(1'b0, 12'h008, 32'h0);
    check("bad read", rd, 32'h0);
    check("bad slverr", er, 1'b1);
    $display("reserved test done");
  endtask : t_rsvd
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_card();
    t_audio();
    t_gpio();
    t_pd();
    t_rsvd();
    stop_test();
  end
  initial begin
    #20000;
    errors++;
    stop_test();
  end
endmodule : card_port0_pin_selector_tb_top

/* pad_load_model.sv */
`timescale 1ns/1ps
module pad_load_model (
  // clock
  input wire logic pclk,
  // selector side
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  input wire logic [5:0] pin_pd_off,
  // far devices
  input wire logic [5:0] ext_val,
  input wire logic [5:0] ext_en,
  output logic [5:0] pin_in
);
  logic [5:0] float_reg = 6'h2a;
  // a floating pad must not hold its last level
  always_ff @(posedge pclk) float_reg <= ~float_reg;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (!pin_pd_off[i]) pin_in[i] = 1'b0;
      else pin_in[i] = float_reg[i];
    end
  end
endmodule : pad_load_model

/* pinmux_pkg.sv */
package pinmux_pkg;

  localparam int unsigned pin_count = 6;
  localparam int unsigned addr_width = 12;

  // register byte addresses
  localparam logic [addr_width-1:0] ext_bus_sel_addr = 12'h000;
  localparam logic [addr_width-1:0] pd_inhibit1_addr = 12'h004;

  // field layout of the external bus selection register
  localparam int unsigned mode_lsb = 0;
  localparam int unsigned mode_width = 2;

  typedef enum logic [1:0] {
    mode_card = 2'b00,
    mode_audio = 2'b01,
    mode_gpio = 2'b10,
    mode_rsvd = 2'b11
  } port_mode_t;

  localparam port_mode_t mode_reset = mode_card;
  localparam logic [pin_count-1:0] pd_off_reset = 6'h00;

  // pin indices in package order
  localparam int unsigned pin_clk = 0;
  localparam int unsigned pin_cmd = 1;
  localparam int unsigned pin_d0 = 2;
  localparam int unsigned pin_d1 = 3;
  localparam int unsigned pin_d2 = 4;
  localparam int unsigned pin_d3 = 5;

  // one group of pin signals: output value, output enable (low drives)
  typedef struct packed {
    logic [pin_count-1:0] dout;
    logic [pin_count-1:0] oe_n;
  } pin_drive_t;

  // card interface: clk and cmd/data, with output enables on cmd and on each data line, none on clk
  typedef struct packed {
    logic clk;
    logic cmd_out;
    logic cmd_oe_n;
    logic [3:0] dat_out;
    logic [3:0] dat_oe_n;
  } card_side_t;

  // audio port: bit clock and frame sync may be inputs in slave mode
  typedef struct packed {
    logic bclk_out;
    logic bclk_oe_n;
    logic fs_out;
    logic fs_oe_n;
    logic tx_data;
  } audio_side_t;

endpackage : pinmux_pkg

/* pinmux_regs.sv */
`timescale 1ns/1ps
module pinmux_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pinmux_pkg::addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration
  output pinmux_pkg::port_mode_t mode,
  output logic [pinmux_pkg::pin_count-1:0] pd_off
);
  pinmux_pkg::port_mode_t mode_reg, mode_next;
  logic [pinmux_pkg::pin_count-1:0] pd_off_reg, pd_off_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic access;
  logic hit_mode;
  logic hit_pd;

  // zero wait states: answer in the first access cycle
  assign access = psel && penable;
  assign hit_mode = (paddr == pinmux_pkg::ext_bus_sel_addr);
  assign hit_pd = (paddr == pinmux_pkg::pd_inhibit1_addr);

  always_comb begin
    mode_next = mode_reg;
    pd_off_next = pd_off_reg;
    prdata_next = 32'h0000_0000;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      pslverr_next = !(hit_mode || hit_pd);
      if (!pwrite && hit_mode) begin
        prdata_next[pinmux_pkg::mode_lsb +: pinmux_pkg::mode_width] = mode_reg;
      end
      if (!pwrite && hit_pd) begin
        prdata_next[pinmux_pkg::pin_count-1:0] = pd_off_reg;
      end
    end
    // answer is loaded at the setup edge and cleared at the access edge,
    // so it stands exactly for the single access cycle
    if (access && pwrite && hit_mode) begin
      mode_next = pinmux_pkg::port_mode_t'(pwdata[pinmux_pkg::mode_lsb +: pinmux_pkg::mode_width]);
    end
    if (access && pwrite && hit_pd) begin
      pd_off_next = pwdata[pinmux_pkg::pin_count-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= pinmux_pkg::mode_reset;
      pd_off_reg <= pinmux_pkg::pd_off_reset;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      pd_off_reg <= pd_off_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign mode = mode_reg;
  assign pd_off = pd_off_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign pready = 1'b1;

endmodule : pinmux_regs

/* pinmux_route.sv */
`timescale 1ns/1ps
module pinmux_route (
  // selection
  input wire pinmux_pkg::port_mode_t mode,
  // functions facing the pins
  input wire pinmux_pkg::card_side_t card,
  input wire pinmux_pkg::audio_side_t audio,
  input wire logic [pinmux_pkg::pin_count-1:0] gpio_out,
  input wire logic [pinmux_pkg::pin_count-1:0] gpio_oe_n,
  // resulting pin drive
  output pinmux_pkg::pin_drive_t drive
);
  always_comb begin
    drive.dout = '0;
    drive.oe_n = '1;
    unique case (mode)
      pinmux_pkg::mode_card: begin
        drive.dout[pinmux_pkg::pin_clk] = card.clk;
        drive.oe_n[pinmux_pkg::pin_clk] = 1'b0;
        drive.dout[pinmux_pkg::pin_cmd] = card.cmd_out;
        drive.oe_n[pinmux_pkg::pin_cmd] = card.cmd_oe_n;
        drive.dout[pinmux_pkg::pin_d3:pinmux_pkg::pin_d0] = card.dat_out;
        drive.oe_n[pinmux_pkg::pin_d3:pinmux_pkg::pin_d0] = card.dat_oe_n;
      end
      pinmux_pkg::mode_audio: begin
        drive.dout[pinmux_pkg::pin_clk] = audio.bclk_out;
        drive.oe_n[pinmux_pkg::pin_clk] = audio.bclk_oe_n;
        drive.dout[pinmux_pkg::pin_cmd] = audio.fs_out;
        drive.oe_n[pinmux_pkg::pin_cmd] = audio.fs_oe_n;
        drive.dout[pinmux_pkg::pin_d0] = audio.tx_data;
        drive.oe_n[pinmux_pkg::pin_d0] = 1'b0;
        // receive data pin stays released
        drive.dout[pinmux_pkg::pin_d3:pinmux_pkg::pin_d2] = gpio_out[pinmux_pkg::pin_d3:pinmux_pkg::pin_d2];
        drive.oe_n[pinmux_pkg::pin_d3:pinmux_pkg::pin_d2] = gpio_oe_n[pinmux_pkg::pin_d3:pinmux_pkg::pin_d2];
      end
      pinmux_pkg::mode_gpio: begin
        drive.dout = gpio_out;
        drive.oe_n = gpio_oe_n;
      end
      pinmux_pkg::mode_rsvd: begin
        // reserved code: all pins released, nothing driven
        drive.dout = '0;
        drive.oe_n = '1;
      end
    endcase
  end

endmodule : pinmux_route
